/* core/pwk_pkg.sv */
// constants and types shared by the wake-up signalling logic
package pwk_pkg;

    // ------------------------------------------------------------
    // config space map
    // ------------------------------------------------------------
    localparam logic [7:0] PWK_PM_REG_OFS = 8'h44;
    localparam int PWK_PSTATE_LSB = 0;
    localparam int PWK_WAKE_EN_BIT = 8;
    localparam int PWK_STATUS_BIT = 15;
    localparam logic [15:0] PWK_PM_REG_RST = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWK_D0 = 2'b00,
        PWK_D1 = 2'b01,
        PWK_D2 = 2'b10,
        PWK_D3 = 2'b11
    } pwk_pstate_t;

    typedef struct packed {
        pwk_pstate_t pstate;
        logic wake_en;
        logic status;
        logic lc_seen;
        logic pme_oe;
        logic pme_o;
        logic rwake;
        logic [15:0] rdata;
        logic rd_valid;
    } pwk_state_t;

    localparam pwk_state_t PWK_STATE_RST = '{
        pstate: PWK_D0, wake_en: 1'b0, status: 1'b0, lc_seen: 1'b0,
        pme_oe: 1'b0, pme_o: 1'b0, rwake: 1'b0, rdata: PWK_PM_REG_RST,
        rd_valid: 1'b0};

endpackage : pwk_pkg

/* core/pwk_link_watch.sv */
// watches the link status level and flags each change
module pwk_link_watch
    import pwk_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // link level
    input wire logic link_up,
    // change pulse
    output logic link_changed
);

    typedef struct packed {
        logic seen;
        logic prev;
    } pwk_lw_t;

    pwk_lw_t st_r;
    pwk_lw_t st_nxt;

    always_comb begin
        st_nxt.seen = 1'b1;
        st_nxt.prev = link_up;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // first sample after reset has no history, so it is not a change
    assign link_changed = st_r.seen && (st_r.prev != link_up);

endmodule : pwk_link_watch

/* core/pwk_wake.sv */
// wake-up event collection, wake status flag and open-drain pme output
module pwk_wake
    import pwk_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // config register port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_byte_en,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    output logic cfg_rd_valid,
    // wake sources
    input wire logic wake_frame_det,
    input wire logic pattern_match_det,
    input wire logic link_up,
    input wire logic port_is_mii,
    // mode controls
    input wire logic link_change_wake_enable,
    input wire logic link_change_detected_clr,
    input wire logic remote_wakeup_mode,
    // status outputs
    output logic link_change_detected,
    output logic [1:0] power_state,
    output logic wake_status_flag,
    output logic wake_signal_enable,
    // wake pins
    output logic remote_wakeup,
    output logic pme_n_o,
    output logic pme_n_oe
);

    // ------------------------------------------------------------
    // state and event decode
    // ------------------------------------------------------------
    pwk_state_t st_r;
    pwk_state_t st_nxt;
    logic link_changed;
    logic hit;
    logic wr_lo;
    logic wr_hi;
    logic clr_status;
    logic lc_set;
    logic wake_ev;

    pwk_link_watch u_link_watch (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .link_up(link_up),
        .link_changed(link_changed)
    );

    function automatic logic [15:0] pm_reg_image(input pwk_state_t s);
        logic [15:0] v;
        v = '0;
        v[PWK_PSTATE_LSB +: 2] = s.pstate;
        v[PWK_WAKE_EN_BIT] = s.wake_en;
        v[PWK_STATUS_BIT] = s.status;
        return v;
    endfunction : pm_reg_image

    assign hit = (cfg_addr == PWK_PM_REG_OFS);
    assign wr_lo = cfg_wr && hit && cfg_byte_en[0];
    assign wr_hi = cfg_wr && hit && cfg_byte_en[1];
    // clear rides on an upper-lane write with bit 15 low, with or without a d0 change
    assign clr_status = wr_hi && !cfg_wdata[PWK_STATUS_BIT];
    // link change counts only on the mii port with its enable set
    assign lc_set = link_changed && link_change_wake_enable
        && port_is_mii;
    assign wake_ev = wake_frame_det
        || (pattern_match_det && port_is_mii)
        || lc_set;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        if (wr_lo) begin
            st_nxt.pstate =
                pwk_pstate_t'(cfg_wdata[PWK_PSTATE_LSB +: 2]);
        end
        if (wr_hi) begin
            st_nxt.wake_en = cfg_wdata[PWK_WAKE_EN_BIT];
        end
        // an event in the clearing cycle wins, so no wake is lost
        if (wake_ev) begin
            st_nxt.status = 1'b1;
        end else if (clr_status) begin
            st_nxt.status = 1'b0;
        end
        if (lc_set) begin
            st_nxt.lc_seen = 1'b1;
        end else if (link_change_detected_clr) begin
            st_nxt.lc_seen = 1'b0;
        end
        st_nxt.pme_oe = st_nxt.status && st_nxt.wake_en;
        st_nxt.pme_o = 1'b0;
        // runs on ref_clk, so a slowed pci clock does not stall it
        st_nxt.rwake = remote_wakeup_mode
            && (st_nxt.status || st_nxt.lc_seen);
        if (cfg_rd) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rdata = hit ? pm_reg_image(st_r) : 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= PWK_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_rdata = st_r.rdata;
    assign cfg_rd_valid = st_r.rd_valid;
    assign link_change_detected = st_r.lc_seen;
    assign power_state = st_r.pstate;
    assign wake_status_flag = st_r.status;
    assign wake_signal_enable = st_r.wake_en;
    assign remote_wakeup = st_r.rwake;
    assign pme_n_o = st_r.pme_o;
    assign pme_n_oe = st_r.pme_oe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_status_set;
        wake_ev |=> st_r.status ##1 (st_r.status || $past(clr_status));
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("wake event did not set status");

    property p_status_sticky;
        st_r.status && !clr_status |=> st_r.status;
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("status dropped without a clear");

    property p_pme_follow;
        pme_n_oe == (st_r.status && st_r.wake_en);
    endproperty
    a_pme_follow: assert property (p_pme_follow)
        else $error("pme drive does not follow status and enable");

    property p_pme_assert;
        wake_ev && st_r.wake_en && !wr_hi |=> pme_n_oe;
    endproperty
    a_pme_assert: assert property (p_pme_assert)
        else $error("wake event did not assert pme");

    property p_pme_gate;
        !st_r.wake_en |-> !pme_n_oe;
    endproperty
    a_pme_gate: assert property (p_pme_gate)
        else $error("pme driven while disabled");

    property p_clear;
        clr_status && !wake_ev |=> !st_r.status && !pme_n_oe;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear write did not clear status");

    property p_d0;
        wr_lo && cfg_wdata[1:0] == 2'b00 |=> power_state == 2'b00;
    endproperty
    a_d0: assert property (p_d0)
        else $error("d0 write not taken");

    property p_en_hold;
        !wr_hi |=> $stable(st_r.wake_en);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable changed without a write");

    property p_read;
        cfg_rd && hit |=> cfg_rd_valid
            && cfg_rdata[15] == $past(st_r.status)
            && cfg_rdata[8] == $past(st_r.wake_en);
    endproperty
    a_read: assert property (p_read)
        else $error("read of 44h returned wrong image");

    property p_mii_gate;
        !port_is_mii |=> !$rose(st_r.lc_seen);
    endproperty
    a_mii_gate: assert property (p_mii_gate)
        else $error("link change seen off the mii port");

    property p_lc;
        lc_set |=> st_r.lc_seen && st_r.status;
    endproperty
    a_lc: assert property (p_lc)
        else $error("link change did not set detected and status");

    // output is registered from the next-state flag, so it follows the mode one cycle later and the flag in the same cycle
    property p_remote_wake;
        remote_wakeup_mode && st_r.status && !clr_status |=> remote_wakeup;
    endproperty
    a_remote_wake: assert property (p_remote_wake)
        else $error("remote wakeup not driven");

    property p_od;
        pme_n_o == 1'b0;
    endproperty
    a_od: assert property (p_od)
        else $error("pme output level not low");

    c_wake_pme: cover property (st_r.wake_en && wake_ev ##1 pme_n_oe);
    c_clear_with_d0: cover property (wr_lo && clr_status);
    c_set_beats_clear: cover property (wake_ev && clr_status);
    c_link_wake: cover property (lc_set ##1 remote_wakeup);

endmodule : pwk_wake

/* tb/pwk_host.sv */
// pci host model: config strobes and the pulled-up pme wire
module pwk_host (
    // clock
    input wire logic ref_clk,
    // config port
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [1:0] cfg_byte_en,
    output logic [15:0] cfg_wdata,
    // wake pin
    input wire logic pme_n_o,
    input wire logic pme_n_oe,
    output logic pme_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // shared wake line idles high through its pull-up
    assign pme_line = pme_n_oe ? pme_n_o : 1'b1;
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 2'b00;
        cfg_wdata = 16'h0000;
    end
    // one access; enable, d0 select and clear are all plain writes
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
            input logic [1:0] be, input logic [15:0] d);
        @(posedge ref_clk);
        cfg_wr <= w;
        cfg_rd <= r;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        // released data bus no longer shows the last value
        cfg_wdata <= ~d;
    endtask : acc
endmodule : pwk_host

/* tb/test_pwk_wake.sv */
// self-checking bench for the wake-up signalling logic
module test_pwk_wake import pwk_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, nrst = 1'b0;
    logic cfg_wr, cfg_rd, cfg_rd_valid, pme_n_o, pme_n_oe, pme_line;
    logic [7:0] cfg_addr;
    logic [1:0] cfg_byte_en, ps;
    logic [15:0] cfg_wdata, cfg_rdata;
    logic wf = 1'b0, pm = 1'b0, link_up = 1'b0, mii = 1'b0, lce = 1'b0;
    logic lclr = 1'b0, rwm = 1'b0, lc_flag, st, en_o, rw;
    int n_errors = 0, checks_done = 0;
    // src {frame, pattern, link toggle, mii, lc enable, wake mode, enable}
    // exp {status, pme pulled, remote wakeup}
    typedef struct packed {
        logic [6:0] src;
        logic [2:0] exp;
    } pwk_row_t;
    pwk_row_t rows [8] = '{'{7'h41, 3'h6}, '{7'h42, 3'h5},
        '{7'h29, 3'h6}, '{7'h21, 3'h0}, '{7'h1F, 3'h7},
        '{7'h15, 3'h0}, '{7'h19, 3'h0}, '{7'h03, 3'h0}};

    always #2.5 ref_clk = ~ref_clk;

    pwk_host host (.ref_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_byte_en,
        .cfg_wdata, .pme_n_o, .pme_n_oe, .pme_line);
    pwk_wake dut (.ref_clk, .nrst, .cfg_wr, .cfg_rd, .cfg_addr,
        .cfg_byte_en, .cfg_wdata, .cfg_rdata, .cfg_rd_valid,
        .wake_frame_det(wf), .pattern_match_det(pm), .link_up,
        .port_is_mii(mii), .link_change_wake_enable(lce),
        .link_change_detected_clr(lclr), .remote_wakeup_mode(rwm),
        .link_change_detected(lc_flag), .power_state(ps),
        .wake_status_flag(st), .wake_signal_enable(en_o),
        .remote_wakeup(rw), .pme_n_o, .pme_n_oe);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #20000;
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(ps, 16'h0000);
        chk(st, 16'h0000);
        chk(pme_line, 16'h0001);
        // --------------------------------------------------------
        // wake sources, gating and modes
        // --------------------------------------------------------
        foreach (rows[i]) begin
            @(posedge ref_clk);
            {mii, lce, rwm} <= rows[i].src[3:1];
            lclr <= 1'b1;
            @(posedge ref_clk);
            lclr <= 1'b0;
            host.acc(1'b1, 1'b0, PWK_PM_REG_OFS, 2'h3,
                {7'h00, rows[i].src[0], 8'h00});
            @(posedge ref_clk);
            {wf, pm} <= rows[i].src[6:5];
            if (rows[i].src[4]) link_up <= ~link_up;
            @(posedge ref_clk);
            {wf, pm} <= 2'h0;
            // sticky results, so the exact latency does not matter here
            repeat (3) @(posedge ref_clk);
            #1;
            chk(en_o, rows[i].src[0]);
            chk(st, rows[i].exp[2]);
            chk(pme_line, {15'h0000, ~rows[i].exp[1]});
            chk(rw, rows[i].exp[0]);
            chk(lc_flag, {15'h0000, &rows[i].src[4:2]});
        end
        // --------------------------------------------------------
        // readback, lane writes, clear and unmapped access
        // --------------------------------------------------------
        @(posedge ref_clk);
        wf <= 1'b1;
        @(posedge ref_clk);
        wf <= 1'b0;
        host.acc(1'b0, 1'b1, PWK_PM_REG_OFS, 2'h3, 16'h0000);
        #1;
        chk(cfg_rdata, 16'h8100);
        host.acc(1'b1, 1'b0, PWK_PM_REG_OFS, 2'h1, 16'h0003);
        #1;
        chk(ps, 16'h0003);
        chk(pme_line, 16'h0000);
        host.acc(1'b1, 1'b0, PWK_PM_REG_OFS, 2'h3, 16'h0100);
        #1;
        chk(ps, 16'h0000);
        chk(st, 16'h0000);
        chk(pme_line, 16'h0001);
        // writing 1 to the flag must leave a pending wake in place
        @(posedge ref_clk);
        wf <= 1'b1;
        @(posedge ref_clk);
        wf <= 1'b0;
        host.acc(1'b1, 1'b0, PWK_PM_REG_OFS, 2'h2, 16'h8100);
        #1;
        chk(st, 16'h0001);
        chk(ps, 16'h0000);
        chk(pme_line, 16'h0000);
        host.acc(1'b0, 1'b1, 8'h48, 2'h3, 16'h0000);
        #1;
        chk(cfg_rd_valid, 16'h0001);
        chk(cfg_rdata, 16'h0000);
        @(posedge ref_clk);
        #1;
        chk(cfg_rd_valid, 16'h0000);
        // --------------------------------------------------------
        // mid-run reset; link level is left high after three toggles, unlike its reset value
        // --------------------------------------------------------
        @(posedge ref_clk);
        {mii, lce} <= 2'h3;
        nrst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(st, 16'h0000);
        chk(en_o, 16'h0000);
        chk(pme_line, 16'h0001);
        @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(st, 16'h0000);
        chk(lc_flag, 16'h0000);
        stop_test();
    end
endmodule : test_pwk_wake
